/* File: logic/tcg_pkg.sv */
package tcg_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_LOW_CMP = 8'h04;
  localparam logic [7:0] OFS_HIGH_CMP = 8'h08;
  localparam logic [7:0] OFS_CARRIER_CTRL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // timer_mode_reg field positions
  localparam int MODE_EN_BIT = 7;
  localparam int MODE_CKS_LSB = 4;
  localparam int MODE_MD_LSB = 2;
  localparam int MODE_LEV_BIT = 1;

  // carrier_control_reg field positions
  localparam int CC_ACTIVE_BIT = 0;
  localparam int CC_BUFFER_BIT = 1;
  localparam int CC_RMC_BIT = 2;

  // status register field positions
  localparam int ST_CARRIER_BIT = 8;
  localparam int ST_SEL_BIT = 9;
  localparam int ST_PEND_BIT = 10;

  // mode encodings
  localparam logic [1:0] MD_CARRIER = 2'h1;

  // reset values
  localparam logic [7:0] RST_CMP = 8'h01;
  localparam logic [7:0] CNT_CLEAR = 8'h00;

  // count clocks a new high width must age before transfer
  localparam logic [1:0] HIGH_AGE_MIN = 2'h3;

  // prescaler width for the count-clock select
  localparam int PRESC_W = 7;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACT_BIT = 1;

  typedef struct packed {
    logic en;
    logic [2:0] cks;
    logic [1:0] md;
    logic lev;
  } tcg_mode_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] ofs;
  } tcg_aphase_t;

endpackage

/* File: logic/tcg_top.sv */
`timescale 1ns/1ps
// How it works
// R1: low compare times low, high compare times high
// R2: software keeps low compare fixed while running
// R3: output low, high or carrier per mode bits
// R4: buffered enable writable, active enable read-only
// R5: companion interrupt synced, copies buffer to active
// R6: count enable starts counting, carrier at default
// R7: low match: irq, invert, clear, use high
// R8: high match: irq, invert, clear, use low
// R9: period N+M+2, high width M+1 clocks
// R10: new high value transfers at old high match
// R11: transfer needs three count clocks of age
// R12: software rewrites high compare after each restart
// R13: software keeps compare values 01h to ffh
// R14: software sets mode bit before starting count
// R15: count clock at least six times companion's
// R16: enabling passes carrier from next rising edge
// R17: disabling keeps current high phase, then low
// R18: software refreshes buffer on each companion irq
// R19: software starts companion counter after this timer
// R20: software stops by clearing count enable
// R21: configuration bit selects output default level
// R22: three-bit field selects the count clock
// R23: stopping clears counter and compare select, output to default level
// R24: behaviour only in carrier mode encoding
module tcg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic companion_irq,
  output logic timer_out_pin,
  output logic match_irq,
  output logic synced_companion_irq
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // count tick when the low sel bits of the prescaler are all ones
  function automatic logic tick_of(input logic [tcg_pkg::PRESC_W-1:0] p, input logic [2:0] sel);
    logic [tcg_pkg::PRESC_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < tcg_pkg::PRESC_W; i++) begin
      mask[i] = (i < int'(sel));
    end
    return (p & mask) == mask;
  endfunction

  function automatic logic [31:0] pad8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  tcg_pkg::tcg_aphase_t aph_r, aph_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  tcg_pkg::tcg_mode_t mode_r, mode_nxt;
  logic [7:0] low_cmp_r, low_cmp_nxt;
  logic [7:0] high_cmp_r, high_cmp_nxt;
  logic [7:0] high_new_r, high_new_nxt;
  logic high_pend_r, high_pend_nxt;
  logic [1:0] high_age_r, high_age_nxt;
  logic buf_en_r, buf_en_nxt;
  logic act_en_r, act_en_nxt;
  logic rmc_r, rmc_nxt;
  logic [tcg_pkg::PRESC_W-1:0] presc_r, presc_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic use_high_r, use_high_nxt;
  logic carrier_r, carrier_nxt;
  logic gate_r, gate_nxt;
  logic comp_s1_r, comp_s2_r, comp_s3_r;
  logic comp_pend_r, comp_pend_nxt;
  logic out_r, out_nxt;
  logic mirq_r, mirq_nxt;
  logic sirq_r, sirq_nxt;
  logic ready_r, ready_nxt;

  logic run;
  logic tick;
  logic wr_mode, wr_low, wr_high, wr_cc;
  logic [7:0] cmp_now;
  logic comp_edge;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  // write strobes land in the data phase of a captured write
  assign wr_mode = aph_r.valid && aph_r.write && aph_r.ofs == tcg_pkg::OFS_MODE;
  assign wr_low = aph_r.valid && aph_r.write && aph_r.ofs == tcg_pkg::OFS_LOW_CMP;
  assign wr_high = aph_r.valid && aph_r.write && aph_r.ofs == tcg_pkg::OFS_HIGH_CMP;
  assign wr_cc = aph_r.valid && aph_r.write && aph_r.ofs == tcg_pkg::OFS_CARRIER_CTRL;

  // address phase capture and read data, ready every cycle
  always_comb begin
    aph_nxt.valid = hsel && hready && htrans[tcg_pkg::HTRANS_ACT_BIT];
    aph_nxt.write = hwrite;
    aph_nxt.ofs = haddr[7:0];
    ready_nxt = 1'b1; // no wait states
    hrdata_nxt = 32'h00000000;
    if (aph_nxt.valid && !hwrite) begin
      case (haddr[7:0])
        tcg_pkg::OFS_MODE: begin
          hrdata_nxt = pad8({mode_r.en, mode_r.cks, mode_r.md, mode_r.lev, 1'b0});
        end
        tcg_pkg::OFS_LOW_CMP: begin
          hrdata_nxt = pad8(low_cmp_r);
        end
        tcg_pkg::OFS_HIGH_CMP: begin
          hrdata_nxt = pad8(high_cmp_r);
        end
        tcg_pkg::OFS_CARRIER_CTRL: begin
          hrdata_nxt[tcg_pkg::CC_ACTIVE_BIT] = act_en_r; // [R4]
          hrdata_nxt[tcg_pkg::CC_BUFFER_BIT] = buf_en_r;
          hrdata_nxt[tcg_pkg::CC_RMC_BIT] = rmc_r;
        end
        tcg_pkg::OFS_STATUS: begin
          hrdata_nxt[7:0] = cnt_r;
          hrdata_nxt[tcg_pkg::ST_CARRIER_BIT] = carrier_r;
          hrdata_nxt[tcg_pkg::ST_SEL_BIT] = use_high_r;
          hrdata_nxt[tcg_pkg::ST_PEND_BIT] = high_pend_r;
        end
        default: begin
          hrdata_nxt = 32'h00000000; // unmapped reads as zero
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
      hrdata_r <= 32'h00000000;
    end else begin
      aph_r <= aph_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ready flop: low in reset, high from the first edge after it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // companion interrupt synchroniser

  // two flops for the foreign level, a third only for the edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
      comp_s3_r <= 1'b0;
    end else begin
      comp_s1_r <= companion_irq;
      comp_s2_r <= comp_s1_r;
      comp_s3_r <= comp_s2_r;
    end
  end

  assign comp_edge = comp_s2_r && !comp_s3_r;

  ////////////////////////////////////////////////////////////////////////
  // count clock and run control

  assign run = mode_r.en && mode_r.md == tcg_pkg::MD_CARRIER; // [R6] [R24]
  assign tick = tick_of(presc_r, mode_r.cks); // [R22]
  assign cmp_now = use_high_r ? high_cmp_r : low_cmp_r; // [R1]

  ////////////////////////////////////////////////////////////////////////
  // registers written by software and the carrier engine

  always_comb begin
    mode_nxt = mode_r;
    low_cmp_nxt = low_cmp_r;
    high_cmp_nxt = high_cmp_r;
    high_new_nxt = high_new_r;
    high_pend_nxt = high_pend_r;
    high_age_nxt = high_age_r;
    buf_en_nxt = buf_en_r;
    act_en_nxt = act_en_r;
    rmc_nxt = rmc_r;
    presc_nxt = presc_r + 1'b1;
    cnt_nxt = cnt_r;
    use_high_nxt = use_high_r;
    carrier_nxt = carrier_r;
    gate_nxt = gate_r;
    comp_pend_nxt = comp_pend_r;
    mirq_nxt = 1'b0;
    sirq_nxt = 1'b0;

    // age the pending high width in count clocks
    if (high_pend_r && run && tick && high_age_r != tcg_pkg::HIGH_AGE_MIN) begin
      high_age_nxt = high_age_r + 1'b1; // [R11]
    end

    if (!run) begin
      // stopped: counter, compare select, carrier, gate and pending companion event back to start
      cnt_nxt = tcg_pkg::CNT_CLEAR; // [R23]
      use_high_nxt = 1'b0;
      carrier_nxt = 1'b0;
      gate_nxt = 1'b0;
      comp_pend_nxt = 1'b0;
    end else if (tick) begin
      if (cnt_r == cmp_now) begin
        mirq_nxt = 1'b1; // [R7] [R8]
        carrier_nxt = !carrier_r;
        cnt_nxt = tcg_pkg::CNT_CLEAR;
        use_high_nxt = !use_high_r; // [R9]
        if (use_high_r && high_pend_r && high_age_r == tcg_pkg::HIGH_AGE_MIN) begin
          high_cmp_nxt = high_new_r; // [R10] [R11]
          high_pend_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
      // gate opens on a carrier rising edge while active enable is set, closes once active enable is clear and carrier is low
      if (act_en_r && !carrier_r && carrier_nxt) begin
        gate_nxt = 1'b1; // [R16]
      end else if (!act_en_r && !carrier_nxt) begin
        gate_nxt = 1'b0; // [R17]
      end
      // synced companion event copies buffer into active on a count clock
      if (comp_pend_r) begin
        sirq_nxt = 1'b1; // [R5]
        act_en_nxt = buf_en_r;
        comp_pend_nxt = 1'b0;
      end
    end
    // a new edge wins over the clear above
    if (run && comp_edge) begin
      comp_pend_nxt = 1'b1; // [R5]
    end

    // software writes
    if (wr_mode) begin
      mode_nxt.en = hwdata[tcg_pkg::MODE_EN_BIT];
      mode_nxt.cks = hwdata[tcg_pkg::MODE_CKS_LSB +: 3];
      mode_nxt.md = hwdata[tcg_pkg::MODE_MD_LSB +: 2];
      mode_nxt.lev = hwdata[tcg_pkg::MODE_LEV_BIT]; // [R21]
    end
    if (wr_low) begin
      low_cmp_nxt = hwdata[7:0];
    end
    // a running write waits for the old high match
    if (wr_high) begin
      if (run) begin
        high_new_nxt = hwdata[7:0]; // [R10]
        high_pend_nxt = 1'b1;
        high_age_nxt = 2'h0; // [R11]
      end else begin
        high_cmp_nxt = hwdata[7:0];
        high_new_nxt = hwdata[7:0];
        high_pend_nxt = 1'b0;
      end
    end
    if (wr_cc) begin
      buf_en_nxt = hwdata[tcg_pkg::CC_BUFFER_BIT]; // [R4]
      rmc_nxt = hwdata[tcg_pkg::CC_RMC_BIT];
    end

    // pin: default level when stopped, else per mode bits
    if (!run) begin
      out_nxt = mode_r.lev; // [R23]
    end else if (!act_en_r && !gate_r) begin
      out_nxt = 1'b0; // [R3]
    end else if (!rmc_r) begin
      out_nxt = act_en_r; // [R3]
    end else begin
      out_nxt = gate_r && carrier_r; // [R3] [R17]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= '0;
      low_cmp_r <= tcg_pkg::RST_CMP;
      high_cmp_r <= tcg_pkg::RST_CMP;
      high_new_r <= tcg_pkg::RST_CMP;
      high_pend_r <= 1'b0;
      high_age_r <= 2'h0;
      buf_en_r <= 1'b0;
      act_en_r <= 1'b0;
      rmc_r <= 1'b0;
      presc_r <= '0;
      cnt_r <= tcg_pkg::CNT_CLEAR;
      use_high_r <= 1'b0;
      carrier_r <= 1'b0;
      gate_r <= 1'b0;
      comp_pend_r <= 1'b0;
      out_r <= 1'b0;
      mirq_r <= 1'b0;
      sirq_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      low_cmp_r <= low_cmp_nxt;
      high_cmp_r <= high_cmp_nxt;
      high_new_r <= high_new_nxt;
      high_pend_r <= high_pend_nxt;
      high_age_r <= high_age_nxt;
      buf_en_r <= buf_en_nxt;
      act_en_r <= act_en_nxt;
      rmc_r <= rmc_nxt;
      presc_r <= presc_nxt;
      cnt_r <= cnt_nxt;
      use_high_r <= use_high_nxt;
      carrier_r <= carrier_nxt;
      gate_r <= gate_nxt;
      comp_pend_r <= comp_pend_nxt;
      out_r <= out_nxt;
      mirq_r <= mirq_nxt;
      sirq_r <= sirq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata = hrdata_r;
  assign hreadyout = ready_r;
  // every transfer completes with an okay response
  assign hresp = 1'b0;
  // pin and pulses leave straight from their flops
  assign timer_out_pin = out_r;
  assign match_irq = mirq_r;
  assign synced_companion_irq = sirq_r;

endmodule

/* File: logic/tcg_dummy_unused.sv */
`timescale 1ns/1ps

/* File: verification/tcg_props.sv */
`timescale 1ns/1ps
module tcg_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic companion_irq,
  input wire logic timer_out_pin,
  input wire logic match_irq,
  input wire logic synced_companion_irq
);
  logic [5:0] hist_r;
  logic [5:0] hist_nxt;
  logic [7:0] since_r;
  logic [7:0] since_nxt;
  logic rd_go;
  ////////////////////////////////////////
  // recent causes that may move the pin
  always_comb begin
    rd_go = hsel && hready && htrans[1] && !hwrite;
    hist_nxt = {hist_r[4:0], match_irq | synced_companion_irq | (hsel && hready && htrans[1] && hwrite)};
    since_nxt = companion_irq ? 8'h00 : (since_r == 8'hff ? since_r : since_r + 8'h01);
  end
  // register the helper state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= 6'h00;
      since_r <= 8'hff;
    end else begin
      hist_r <= hist_nxt;
      since_r <= since_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  property p_idle_rd; !$past(rd_go) |-> hrdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data outside data phase");
  property p_upper; hrdata[31:11] == 21'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_match_pulse; match_irq |=> !match_irq; endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match pulse too long");
  property p_sync_pulse; synced_companion_irq |=> !synced_companion_irq; endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
  property p_sync_cause; synced_companion_irq |-> since_r <= 8'h8c; endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("sync pulse without cause");
  property p_out_cause; $changed(timer_out_pin) |-> hist_r != 6'h00; endproperty
  a_out_cause: assert property (p_out_cause) else $error("pin moved without cause");
  c_match: cover property (match_irq);
  c_sync: cover property (synced_companion_irq);
  c_pin: cover property ($rose(timer_out_pin));
endmodule

bind tcg_top tcg_props u_props (.*);

/* File: verification/tcg_companion_model.sv */
`timescale 1ns/1ps
module tcg_companion_model #(
  parameter int PERIOD = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic companion_irq
);
  int cnt_r;
  // periodic interrupt, two clocks wide, far slower than the count clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      companion_irq <= 1'b0;
    end else if (run) begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      companion_irq <= cnt_r < 2;
    end
  end
endmodule

/* File: verification/test_timer_carrier_generator.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_timer_carrier_generator;
  localparam logic [7:0] MD = tcg_pkg::OFS_MODE;
  localparam logic [7:0] LO = tcg_pkg::OFS_LOW_CMP;
  localparam logic [7:0] HI = tcg_pkg::OFS_HIGH_CMP;
  localparam logic [7:0] CC = tcg_pkg::OFS_CARRIER_CTRL;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic comp_run = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, companion_irq, timer_out_pin, match_irq, synced_companion_irq;
  int err_total = 0;
  int cmp_count = 0;
  // 40 MHz clock
  always #12.5 hclk = ~hclk;
  tcg_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .companion_irq(companion_irq), .timer_out_pin(timer_out_pin), .match_irq(match_irq),
    .synced_companion_irq(synced_companion_irq));
  tcg_companion_model u_comp (.clk(hclk), .rst_n(hresetn), .run(comp_run), .companion_irq(companion_irq));
  ////////////////////////////////////////
  // one single word transfer, read data taken at the data phase end
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, ofs};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // bounded wait for a pin level
  task automatic lvl_wait(input logic lvl);
    for (int n = 0; n < 600 && timer_out_pin !== lvl; n++) @(posedge hclk);
  endtask
  // high width and period of the next full pin pulse
  task automatic measure(output int hi, output int per);
    lvl_wait(1'b0);
    lvl_wait(1'b1);
    for (hi = 0; hi < 600 && timer_out_pin === 1'b1; hi++) @(posedge hclk);
    for (per = hi; per < 600 && timer_out_pin === 1'b0; per++) @(posedge hclk);
  endtask
  // bounded wait for the synced companion pulse, then let the pin settle
  task automatic sirq_wait;
    repeat (2) @(posedge hclk);
    for (int n = 0; n < 200 && synced_companion_irq !== 1'b1; n++) @(posedge hclk);
    repeat (2) @(posedge hclk);
  endtask
  function automatic logic [31:0] mw(input logic en, input logic [2:0] cks, input logic lev);
    return {24'h0, en, cks, tcg_pkg::MD_CARRIER, lev, 1'b0};
  endfunction
  ////////////////////////////////////////
  task automatic t_reset;
    bus(0, MD, 0); `CHK(rd, 32'h0)
    bus(0, LO, 0); `CHK(rd, {24'h0, tcg_pkg::RST_CMP})
    bus(0, HI, 0); `CHK(rd, {24'h0, tcg_pkg::RST_CMP})
    bus(0, 8'h14, 0); `CHK(rd, 32'h0)
    bus(1, CC, 32'h7);
    bus(0, CC, 0); `CHK(rd, 32'h6)
  endtask
  task automatic t_carrier(input logic [7:0] n, input logic [7:0] m, input logic [2:0] cks);
    int hi, per;
    bus(1, LO, {24'h0, n});
    bus(1, HI, {24'h0, m});
    bus(1, CC, 32'h6);
    bus(1, MD, mw(1'b1, cks, 1'b0));
    comp_run <= 1'b1;
    measure(hi, per);
    `CHK(hi, (int'(m) + 1) << cks)
    `CHK(per, (int'(n) + int'(m) + 2) << cks)
  endtask
  task automatic t_high_update;
    int hi, per;
    bus(1, HI, 32'h3);
    bus(0, HI, 0); `CHK(rd, 32'h1)
    repeat (20) @(posedge hclk);
    measure(hi, per);
    `CHK(hi, 4)
    bus(0, HI, 0); `CHK(rd, 32'h3)
  endtask
  task automatic t_stop;
    bus(1, MD, mw(1'b0, 3'h0, 1'b1));
    repeat (3) @(posedge hclk);
    `CHK(timer_out_pin, 1'b1)
    bus(0, tcg_pkg::OFS_STATUS, 0); `CHK({rd[tcg_pkg::ST_SEL_BIT], rd[7:0]}, 9'h0)
    bus(1, MD, 32'h82); // enabled, but mode field not carrier
    repeat (3) @(posedge hclk);
    `CHK(timer_out_pin, 1'b1)
    bus(0, tcg_pkg::OFS_STATUS, 0); `CHK(rd[7:0], 8'h0)
    bus(1, MD, mw(1'b0, 3'h0, 1'b0));
    repeat (3) @(posedge hclk);
    `CHK(timer_out_pin, 1'b0)
  endtask
  // clearing the buffer mid-run: every pin pulse stays full width, then low
  task automatic t_gate_close(input int hw);
    int hi;
    hi = 0;
    bus(1, CC, 32'h4);
    lvl_wait(1'b0);
    repeat (300) begin
      @(posedge hclk);
      if (timer_out_pin === 1'b1) begin
        hi++;
      end else if (hi != 0) begin
        `CHK(hi, hw)
        hi = 0;
      end
    end
    `CHK(timer_out_pin, 1'b0)
  endtask
  task automatic t_rmc0;
    bus(1, CC, 32'h2);
    bus(1, MD, mw(1'b1, 3'h0, 1'b0));
    sirq_wait;
    `CHK(timer_out_pin, 1'b1)
    bus(0, CC, 0); `CHK(rd[tcg_pkg::CC_ACTIVE_BIT], 1'b1)
    bus(1, CC, 32'h0);
    sirq_wait;
    `CHK(timer_out_pin, 1'b0)
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_carrier(8'h03, 8'h01, 3'h0);
    t_high_update;
    t_stop;
    t_carrier(8'h02, 8'h04, 3'h1);
    t_gate_close(10);
    t_stop;
    t_rmc0;
    conclude;
  end
  // watchdog
  initial begin
    #500000;
    err_total++;
    conclude;
  end
endmodule
